// *** sbra_regs.vh ***
// Address map and subaddress constants for the subbank register access block.
// Assumes a 7-bit core data address and 16-bit data words.
`ifndef SBRA_REGS_VH
`define SBRA_REGS_VH

// Direct data addresses
`define SBRA_ADDR_W          7
`define SBRA_A_SER2_PTR      7'h34
`define SBRA_A_SER2_WIN      7'h35
`define SBRA_A_SER0_PTR      7'h38
`define SBRA_A_SER0_WIN      7'h39
`define SBRA_A_SER1_PTR      7'h48
`define SBRA_A_SER1_WIN      7'h49
`define SBRA_A_XFER_PREC     7'h54
`define SBRA_A_XFER_PTR      7'h55
`define SBRA_A_XFER_WIN_INC  7'h56
`define SBRA_A_XFER_WIN_PLN  7'h57

// Serial subbank layout
`define SBRA_SER_HOLE        5'h0f
`define SBRA_SER_LAST        5'h1b
`define SBRA_SER_DEPTH       28

// Transfer subbank layout: 6 channels x 5 registers, then the program page
`define SBRA_XFER_LAST       5'h1e
`define SBRA_XFER_DEPTH      31

// Reset values
`define SBRA_PTR_RST         16'h0000
`define SBRA_REG_RST         16'h0000

`endif

// *** sbra_bank.v ***
// One subbank: pointer plus its array of control registers.
// Assumes one-cycle read/write strobes from the core, already address-decoded.
`include "sbra_regs.vh"
module sbra_bank #(
  parameter DEPTH   = 28,
  parameter [4:0] HOLE = 5'h0f,
  parameter [4:0] LAST = 5'h1b,
  parameter HAS_HOLE = 1
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ptr_wr,
  input  wire        win_wr,
  input  wire        win_rd,
  input  wire        inc_en,
  input  wire [15:0] wdata,
  output reg  [15:0] pointer,
  output wire [15:0] win_data
);
  reg [15:0] regs [0:DEPTH-1];
  integer i;

  // Subaddress is mapped when in range and not the gap
  function mapped;
    input [15:0] p;
    begin
      mapped = (p <= {11'h000, LAST}) && !(HAS_HOLE != 0 && p == {11'h000, HOLE});
    end
  endfunction

  wire hit = mapped(pointer);

  // Selected register, zero when unmapped
  assign win_data = hit ? regs[pointer[4:0]] : `SBRA_REG_RST;

  // Pointer load and post-increment
  always @(posedge clk) begin
    if (!resetn) begin
      pointer <= `SBRA_PTR_RST;
    end else if (ptr_wr) begin
      pointer <= wdata;
    end else if (inc_en && (win_wr || win_rd)) begin
      pointer <= pointer + 16'h0001;
    end
  end

  // Register array; writes to unmapped subaddresses are dropped
  always @(posedge clk) begin
    if (!resetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        regs[i] <= `SBRA_REG_RST;
      end
    end else if (win_wr && hit) begin
      regs[pointer[4:0]] <= wdata;
    end
  end
endmodule

// *** sbra_top.v ***
// Subbank register access for three serial-port subbanks and the transfer subbank.
// Assumes the core issues single-cycle rd/wr strobes with address and write data.
//
// How it works
// - Serial pointer write selects one subbank register
// - Serial window reads/writes the selected register
// - Serial windows at 39h, 49h, 35h
// - Subaddresses 00h-0Eh map the control registers
// - Subaddresses 10h-1Bh map enable partitions C-H
// - Priority/enable control is a direct register
// - Transfer pointer selects next window target
// - Two transfer windows, incrementing and plain
// - Incrementing window bumps pointer after access
// - Subaddresses 00h-1Dh: five registers per channel
// - Subaddress 1Eh is shared source program page
// - Serial pointers at 38h, 48h, 34h
// - Transfer pointer 55h, windows 56h and 57h
`include "sbra_regs.vh"
module sbra_top (
  input  wire        clk,
  input  wire        resetn,
  input  wire [6:0]  addr,
  input  wire        rd,
  input  wire        wr,
  input  wire [15:0] wdata,
  output reg  [15:0] rdata,
  output reg         rvalid,
  output wire        hit,
  output reg  [15:0] xfer_priority_enable_ctl
);
  // Address decode
  function is_at;
    input [6:0] a;
    input [6:0] b;
    begin
      is_at = (a == b);
    end
  endfunction

  wire s0p = is_at(addr, `SBRA_A_SER0_PTR);
  wire s1p = is_at(addr, `SBRA_A_SER1_PTR);
  wire s2p = is_at(addr, `SBRA_A_SER2_PTR);
  wire s0w = is_at(addr, `SBRA_A_SER0_WIN);
  wire s1w = is_at(addr, `SBRA_A_SER1_WIN);
  wire s2w = is_at(addr, `SBRA_A_SER2_WIN);
  wire xpr = is_at(addr, `SBRA_A_XFER_PREC);
  wire xp  = is_at(addr, `SBRA_A_XFER_PTR);
  wire xwi = is_at(addr, `SBRA_A_XFER_WIN_INC);
  wire xwn = is_at(addr, `SBRA_A_XFER_WIN_PLN);
  wire xw  = xwi | xwn;

  assign hit = s0p | s1p | s2p | s0w | s1w | s2w | xpr | xp | xw;

  wire [15:0] s0_ptr;
  wire [15:0] s1_ptr;
  wire [15:0] s2_ptr;
  wire [15:0] x_ptr;
  wire [15:0] s0_dat;
  wire [15:0] s1_dat;
  wire [15:0] s2_dat;
  wire [15:0] x_dat;

  // Serial subbanks: control set 00h-0Eh, gap at 0Fh, partitions to 1Bh
  sbra_bank #(.DEPTH(`SBRA_SER_DEPTH), .HOLE(`SBRA_SER_HOLE),
              .LAST(`SBRA_SER_LAST), .HAS_HOLE(1)) u_ser0 (
    .clk(clk), .resetn(resetn), .ptr_wr(wr & s0p), .win_wr(wr & s0w),
    .win_rd(rd & s0w), .inc_en(1'b0), .wdata(wdata),
    .pointer(s0_ptr), .win_data(s0_dat));
  sbra_bank #(.DEPTH(`SBRA_SER_DEPTH), .HOLE(`SBRA_SER_HOLE),
              .LAST(`SBRA_SER_LAST), .HAS_HOLE(1)) u_ser1 (
    .clk(clk), .resetn(resetn), .ptr_wr(wr & s1p), .win_wr(wr & s1w),
    .win_rd(rd & s1w), .inc_en(1'b0), .wdata(wdata),
    .pointer(s1_ptr), .win_data(s1_dat));
  sbra_bank #(.DEPTH(`SBRA_SER_DEPTH), .HOLE(`SBRA_SER_HOLE),
              .LAST(`SBRA_SER_LAST), .HAS_HOLE(1)) u_ser2 (
    .clk(clk), .resetn(resetn), .ptr_wr(wr & s2p), .win_wr(wr & s2w),
    .win_rd(rd & s2w), .inc_en(1'b0), .wdata(wdata),
    .pointer(s2_ptr), .win_data(s2_dat));

  // Transfer subbank: 30 channel registers then shared page at 1Eh
  sbra_bank #(.DEPTH(`SBRA_XFER_DEPTH), .HOLE(`SBRA_SER_HOLE),
              .LAST(`SBRA_XFER_LAST), .HAS_HOLE(0)) u_xfer (
    .clk(clk), .resetn(resetn), .ptr_wr(wr & xp), .win_wr(wr & xw),
    .win_rd(rd & xw), .inc_en(xwi), .wdata(wdata),
    .pointer(x_ptr), .win_data(x_dat));

  // Direct priority/enable control register
  always @(posedge clk) begin
    if (!resetn) begin
      xfer_priority_enable_ctl <= `SBRA_REG_RST;
    end else if (wr & xpr) begin
      xfer_priority_enable_ctl <= wdata;
    end
  end

  // Read mux, sampled before any post-increment takes effect
  reg [15:0] next_rdata;
  always @* begin
    next_rdata = 16'h0000;
    if (s0p) next_rdata = s0_ptr;
    if (s1p) next_rdata = s1_ptr;
    if (s2p) next_rdata = s2_ptr;
    if (xp)  next_rdata = x_ptr;
    if (s0w) next_rdata = s0_dat;
    if (s1w) next_rdata = s1_dat;
    if (s2w) next_rdata = s2_dat;
    if (xw)  next_rdata = x_dat;
    if (xpr) next_rdata = xfer_priority_enable_ctl;
  end

  // Registered read data, one cycle after the strobe
  always @(posedge clk) begin
    if (!resetn) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd;
      if (rd) begin
        rdata <= next_rdata;
      end
    end
  end
endmodule

// *** sbra_chk_asserts.sv ***
// Checker for the subbank access ports.
// Assumes one clock and an active-low reset.
module sbra_chk (
  input wire clk, resetn, rd, wr, rvalid, hit,
  input wire [6:0] addr,
  input wire [15:0] wdata, rdata, xfer_priority_enable_ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Pointer and window strobes
  wire w55 = wr && addr == 7'h55;
  wire r55 = rd && addr == 7'h55;
  wire w39 = wr && addr == 7'h39;
  property p_rv; rd |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("rvalid missing");
  property p_nrv; !rd |=> !rvalid; endproperty
  a_nrv: assert property (p_nrv) else $error("rvalid stray");
  property p_hit; hit == (addr inside {7'h34, 7'h35, 7'h38, 7'h39, 7'h48, 7'h49, [7'h54:7'h57]}); endproperty
  a_hit: assert property (p_hit) else $error("decode");
  property p_dir; wr && addr == 7'h54 |=> xfer_priority_enable_ctl == $past(wdata); endproperty
  a_dir: assert property (p_dir) else $error("direct reg");
  property p_ptr; w55 ##1 r55 |=> rdata == $past(wdata, 2); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer");
  property p_inc; w55 ##1 wr && addr == 7'h56 ##1 r55 |=> rdata == $past(wdata, 3) + 16'h0001; endproperty
  a_inc: assert property (p_inc) else $error("increment");
  property p_pln; w55 ##1 wr && addr == 7'h57 ##1 r55 |=> rdata == $past(wdata, 3); endproperty
  a_pln: assert property (p_pln) else $error("plain");
  property p_win; wr && addr == 7'h38 ##1 w39 ##1 rd && addr == 7'h39 |=> rdata == $past(wdata, 2); endproperty
  a_win: assert property (p_win) else $error("serial window");
  c_rd: cover property (rvalid);
  c_inc: cover property (w55 ##1 wr && addr == 7'h56);
  c_dir: cover property (wr && addr == 7'h54);
endmodule
bind sbra_top sbra_chk u_chk (.clk(clk), .resetn(resetn), .rd(rd), .wr(wr), .rvalid(rvalid), .hit(hit),
  .addr(addr), .wdata(wdata), .rdata(rdata), .xfer_priority_enable_ctl(xfer_priority_enable_ctl));

// *** sbra_core.sv ***
// Core model: one-cycle data-bus reads and writes.
// Assumes a read answer one clock after the strobe.
module sbra_core (
  input wire clk, rvalid,
  input wire [15:0] rdata,
  output logic rd = 1'b0, wr = 1'b0,
  output logic [6:0] addr = 7'h00,
  output logic [15:0] wdata = 16'h0000
);
  timeunit 1ns; timeprecision 1ns;
  // Write; strobe stays up only until the next call replaces it
  task automatic put(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    {addr, rd, wr, wdata} <= {a, 2'b01, d};
  endtask
  // Read; data bus carries junk, strobe drops at the answer edge
  task automatic get(input logic [6:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    {addr, rd, wr, wdata} <= {a, 2'b10, ~wdata};
    @(posedge clk);
    rd <= 1'b0;
    #1 {d, ok} = {rdata, rvalid};
  endtask
endmodule

// *** tb.sv ***
// Bench: register walks through the core model with read-back checks.
// Assumes sbra_top answers reads one clock later.
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, rd, wr, rvalid, hit;
  logic [6:0] addr, sp [3] = '{7'h38, 7'h48, 7'h34};
  logic [15:0] wdata, rdata, prec;
  int fail_count = 0, n_checks = 0;
  sbra_core CORE (.clk(clk), .rvalid(rvalid), .rdata(rdata), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata));
  sbra_top DUT (.clk(clk), .resetn(resetn), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid), .hit(hit), .xfer_priority_enable_ctl(prec));
  // Clock, 100 ns period
  initial forever #50 clk = ~clk;
  // Read one address and compare
  task automatic chk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    logic ok;
    CORE.get(a, v, ok);
    n_checks++;
    if (v !== e || ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t addr %h got %h exp %h", $time, a, v, e);
    end
    n_checks++;
    if (hit !== (a inside {7'h34, 7'h35, 7'h38, 7'h39, 7'h48, 7'h49, [7'h54:7'h57]})) begin
      fail_count++;
      $display("[ERR] %0t addr %h decode flag %b", $time, a, hit);
    end
  endtask
  // Verdict
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    chk(7'h55, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      CORE.put(sp[p], 16'h0002);
      CORE.put(sp[p] + 7'h01, 16'h1230 + 16'(p));
      chk(sp[p] + 7'h01, 16'h1230 + 16'(p));
    end
    for (int p = 0; p < 3; p++) chk(sp[p] + 7'h01, 16'h1230 + 16'(p));
    for (int i = 0; i < 29; i++) begin
      CORE.put(7'h48, 16'(i));
      CORE.put(7'h49, 16'ha500 + 16'(i));
      chk(7'h49, (i == 15 || i > 27) ? 16'h0000 : 16'ha500 + 16'(i));
    end
    CORE.put(7'h55, 16'h0000);
    for (int i = 0; i < 31; i++) CORE.put(7'h56, 16'hc000 + 16'(i));
    chk(7'h55, 16'h001f);
    CORE.put(7'h55, 16'h0000);
    for (int i = 0; i < 31; i++) chk(7'h56, 16'hc000 + 16'(i));
    CORE.put(7'h55, 16'h0007);
    CORE.put(7'h57, 16'h5a5a);
    chk(7'h55, 16'h0007);
    chk(7'h57, 16'h5a5a);
    CORE.put(7'h55, 16'h001d);
    CORE.put(7'h56, 16'h0f0f);
    chk(7'h55, 16'h001e);
    chk(7'h56, 16'hc01e);
    CORE.put(7'h54, 16'habcd);
    chk(7'h54, 16'habcd);
    n_checks++;
    if (prec !== 16'habcd) begin
      fail_count++;
      $display("[ERR] %0t direct control output %h", $time, prec);
    end
    CORE.put(7'h36, 16'hffff);
    chk(7'h36, 16'h0000);
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) resetn <= 1'b1;
    chk(7'h55, 16'h0000);
    summarize;
  end
endmodule
